// File: bct_term.sv
// bct_term: ends processor bus cycles on burst ready or ordinary ready,
// drives the last-transfer pin and latches read data per transfer.
// assumes the partner drives the ready pins low-true, a pull-up when undriven,
// and that the core holds i_start/i_req only while o_busy is low.
`timescale 1ns/1ps
module bct_term
	import bct_pkg::*;
(
	input  wire logic                      i_clk_sys,          // bus clock 125 MHz
	input  wire logic                      i_rst,              // async reset, high
	input  wire logic                      i_start,            // start cycle, one pulse
	input  wire bct_pkg::bct_req_t         i_req,              // cycle kind with start
	input  wire logic                      i_hold,             // bus surrendered
	input  wire logic                      i_burst_ready_n,    // burst ready pin, low-true
	input  wire logic                      i_ready_n,          // ordinary ready pin, low-true
	input  wire logic [bct_pkg::BCT_DATA_W-1:0] i_data,        // data bus pins
	output logic                           o_final_transfer_n, // last-transfer pin out
	output logic                           o_final_transfer_oe,// high while driven
	output logic                           o_busy,             // cycle in progress
	output bct_pkg::bct_beat_t             o_beat              // transfer report
);
	import bct_pkg::*;

	logic                  bst_ready_s;     // synchronised burst ready, low-true
	logic                  rdy_s;           // synchronised ordinary ready, low-true
	logic                  hold_s;          // synchronised hold request
	logic [BCT_DATA_W-1:0] data_s1;         // data first stage
	logic [BCT_DATA_W-1:0] data_s2;         // data second stage
	bct_state_t            state;           // bus cycle state
	bct_state_t            next_state;      // next cycle state
	bct_req_t              req;             // kind of running cycle
	bct_req_t              next_req;        // next kind
	logic [1:0]            left;            // transfers remaining minus one
	logic [1:0]            next_left;       // next remaining
	logic [1:0]            idx;             // transfer index
	logic [1:0]            next_idx;        // next index
	logic                  next_ft_n;       // next last-transfer level
	logic                  next_ft_oe;      // next output enable
	logic                  next_busy;       // next busy
	bct_beat_t             next_beat;       // next report
	logic                  bst_hit;         // burst ready counted this clock
	logic                  rdy_hit;         // ordinary ready counted this clock
	logic                  done;            // cycle ends this clock

	// ready pins arrive asynchronously; pull-up makes idle read as high
	bct_sync #(.RST_VAL(BCT_PIN_IDLE)) u_sync_bst (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_pin     (i_burst_ready_n),
		.o_level   (bst_ready_s)
	);
	bct_sync #(.RST_VAL(BCT_PIN_IDLE)) u_sync_rdy (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_pin     (i_ready_n),
		.o_level   (rdy_s)
	);
	bct_sync #(.RST_VAL(1'b0)) u_sync_hold (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_pin     (i_hold),
		.o_level   (hold_s)
	);

	// last transfer when nothing is left to count
	function automatic logic is_last(input logic [1:0] rem);
		is_last = (rem == BCT_LEN_ONE);
	endfunction

	// next-state logic for the cycle
	always_comb begin
		next_state = state;
		next_req   = req;
		next_left  = left;
		next_idx   = idx;
		next_beat  = '0;
		next_beat.data = o_beat.data;
		// only low counts as ready; high or floating is not ready
		// sampling only in the second clock onward
		rdy_hit  = (state == BCT_XFER) && !rdy_s;
		bst_hit  = (state == BCT_XFER) && !bst_ready_s && rdy_s;  // ordinary ready overrides
		// finish on burst ready during last transfer, or on any ordinary ready
		done     = rdy_hit || (bst_hit && is_last(left));
		case (state)
			BCT_IDLE: begin
				if (i_start && !hold_s) begin
					next_state = BCT_FIRST;
					next_req   = i_req;
					next_left  = i_req.burst ? BCT_LEN_BURST : BCT_LEN_ONE;
					next_idx   = 2'h0;
				end
			end
			BCT_FIRST: begin
				next_state = BCT_XFER;  // ready ignored at end of first clock
			end
			BCT_XFER: begin
				if (rdy_hit || bst_hit) begin
					next_beat.valid = 1'b1;
					next_beat.last  = done;
					next_beat.abort = rdy_hit && !bst_ready_s;
					next_beat.index = idx;
					// read data captured on every counted ready
					if (!req.write) begin
						next_beat.data = data_s2;
					end
					next_idx  = idx + 2'h1;
					next_left = left - 2'h1;
				end
				if (done) begin
					next_state = BCT_IDLE;  // next cycle may start
				end
			end
			default: begin
				next_state = BCT_IDLE;
			end
		endcase
		// released in hold, asserted on last transfer of any cycle
		next_ft_oe = !hold_s;
		next_ft_n  = !((next_state != BCT_IDLE) && is_last(next_left));
		next_busy  = (next_state != BCT_IDLE);
	end

	// registers only
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state              <= BCT_IDLE;
			req                <= '0;
			left               <= BCT_LEN_ONE;
			idx                <= 2'h0;
			data_s1            <= BCT_DATA_RST;
			data_s2            <= BCT_DATA_RST;
			o_final_transfer_n <= BCT_PIN_IDLE;
			o_final_transfer_oe <= 1'b0;
			o_busy             <= 1'b0;
			o_beat             <= '0;
		end else begin
			state              <= next_state;
			req                <= next_req;
			left               <= next_left;
			idx                <= next_idx;
			data_s1            <= i_data;   // aligned with the ready synchronisers
			data_s2            <= data_s1;
			o_final_transfer_n <= next_ft_n;
			o_final_transfer_oe <= next_ft_oe;
			o_busy             <= next_busy;
			o_beat             <= next_beat;
		end
	end

	// assertions on design-driven signals, all taken after the pin synchronisers
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// counted burst ready on a read lands the aligned data
	AST_READ_LATCH: assert property (
		(state == BCT_XFER && !bst_ready_s && rdy_s && !req.write)
		|=> (o_beat.valid && o_beat.data == $past(data_s2)))
		else $error("read data not latched on burst ready");

	// writes never disturb the last read data held in the report
	AST_WRITE_KEEP: assert property (
		(state == BCT_XFER && req.write) |=> $stable(o_beat.data))
		else $error("read data changed during a write cycle");

	// ordinary ready wins over burst ready and ends the cycle
	AST_ABORT: assert property (
		(state == BCT_XFER && !rdy_s) |=> (o_beat.last && state == BCT_IDLE))
		else $error("ordinary ready did not end the cycle");

	// both pins high means nothing is counted
	AST_NO_HIGH: assert property (
		(state == BCT_XFER && bst_ready_s && rdy_s) |=> !o_beat.valid)
		else $error("transfer counted with ready lines high");

	// a cycle closed by burst ready had last-transfer low the clock before;
	// an ordinary-ready ending is left out, it may cut a burst short
	AST_LAST_MARK: assert property (
		(o_beat.valid && o_beat.last && !o_beat.abort && $past(rdy_s))
		|-> !$past(o_final_transfer_n))
		else $error("cycle ended without last-transfer asserted");

	// a burst opens with last-transfer high, more transfers still to come
	AST_BURST_START: assert property (
		(state == BCT_IDLE && i_start && !hold_s && i_req.burst)
		|=> (o_busy && o_final_transfer_n))
		else $error("burst started with last-transfer asserted");

	// no cycle running, no last-transfer
	AST_IDLE_PIN: assert property (
		!o_busy |-> o_final_transfer_n)
		else $error("last-transfer asserted with no cycle running");

	// a single transfer carries last-transfer from its first clock
	AST_SINGLE_LAST: assert property (
		(state == BCT_IDLE && i_start && !hold_s && !i_req.burst)
		|=> (!o_final_transfer_n || !o_final_transfer_oe))
		else $error("single cycle missing last-transfer");

	// hold releases the pin one clock after the synchronised request
	AST_HOLD_FLOAT: assert property (
		hold_s |=> !o_final_transfer_oe)
		else $error("last-transfer driven during hold");

	// idle and first clock never produce a transfer
	AST_FIRST_IGNORE: assert property (
		(state != BCT_XFER) |=> !o_beat.valid)
		else $error("ready taken outside sampling clocks");

	// the first clock always hands over to the sampling clocks
	AST_FIRST_NEXT: assert property (
		(state == BCT_FIRST) |=> (state == BCT_XFER))
		else $error("first clock not followed by sampling clock");

	// burst ready in the second clock is already counted
	AST_SAMPLE_LATER: assert property (
		(state == BCT_FIRST) ##1 (!bst_ready_s) |=> o_beat.valid)
		else $error("burst ready not sampled in second clock");

	// burst ready under last-transfer frees the bus for the next cycle
	AST_FINISH: assert property (
		(state == BCT_XFER && !bst_ready_s && rdy_s && !o_final_transfer_n)
		|=> (state == BCT_IDLE && !o_busy))
		else $error("cycle not finished on last burst ready");

	// main scenarios: single, full burst, early abort, hold
	COV_SINGLE: cover property (state == BCT_XFER && !req.burst ##1 o_beat.last);
	COV_BURST: cover property (o_beat.valid && o_beat.index == 2'h3 && o_beat.last);
	COV_ABORT: cover property (o_beat.valid && o_beat.abort);
	COV_HOLD: cover property (hold_s && !o_final_transfer_oe);
endmodule

// File: bct_pkg.sv
// bct_pkg: shared types and constants for the bus cycle termination block
// assumes a single 125 MHz bus clock and an external cycle requester
package bct_pkg;
	localparam int          BCT_DATA_W   = 32;         // data bus width
	localparam int          BCT_BURST_W  = 2;          // transfer index width
	localparam logic [1:0]  BCT_LEN_ONE  = 2'h0;       // count-1 for single transfer
	localparam logic [1:0]  BCT_LEN_BURST = 2'h3;      // count-1 for four-beat burst
	localparam logic        BCT_PIN_IDLE = 1'h1;       // inactive level of low-true pins
	localparam logic [BCT_DATA_W-1:0] BCT_DATA_RST = 32'h0000_0000; // read data at reset

	// bus cycle state, gray along idle -> first -> rest; both bits change from rest back to idle
	typedef enum logic [1:0] {
		BCT_IDLE  = 2'b00,  // no cycle on the bus
		BCT_FIRST = 2'b01,  // first clock, ready ignored
		BCT_XFER  = 2'b11   // second and later clocks, ready sampled
	} bct_state_t;

	// cycle request from the core side
	typedef struct packed {
		logic       burst;  // four transfers instead of one
		logic       write;  // write cycle, else read
	} bct_req_t;

	// per-transfer report to the core side
	typedef struct packed {
		logic                  valid;  // one transfer finished
		logic                  last;   // cycle finished with it
		logic                  abort;  // ended by ordinary ready with burst ready also low
		logic [BCT_BURST_W-1:0] index;  // transfer number in the cycle
		logic [BCT_DATA_W-1:0]  data;   // latched read data
	} bct_beat_t;
endpackage

// File: bct_sync.sv
// bct_sync: two-flop synchroniser for one pin level
// assumes the pin is sampled against i_clk_sys only
`timescale 1ns/1ps
module bct_sync #(
	parameter logic RST_VAL = 1'b1          // level held during reset
) (
	input  wire logic i_clk_sys,            // bus clock
	input  wire logic i_rst,                // async reset, high
	input  wire logic i_pin,                // raw pin level
	output logic      o_level               // synchronised level
);
	logic meta;                             // first stage, read only by o_level
	logic next_meta;                        // next first stage
	logic next_level;                       // next second stage

	// no logic between the stages
	always_comb begin
		next_meta  = i_pin;
		next_level = meta;
	end

	// registers only
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			meta    <= RST_VAL;
			o_level <= RST_VAL;
		end else begin
			meta    <= next_meta;
			o_level <= next_level;
		end
	end
endmodule

// File: bct_partner.sv
// bct_partner: far-side bus controller answering on the ready pins
// assumes the testbench calls give() just after a rising clock edge
`timescale 1ns/1ps
module bct_partner
	import bct_pkg::*;
(
	input  wire logic                  i_clk_sys,       // bus clock
	output logic                       o_burst_ready_n, // burst ready pin
	output logic                       o_ready_n,       // ordinary ready pin
	output logic [BCT_DATA_W-1:0]      o_data           // data bus pins
);
	// pins rest high, as the pull-up leaves them when undriven
	initial begin
		o_burst_ready_n = BCT_PIN_IDLE;
		o_ready_n       = BCT_PIN_IDLE;  // ordinary ready idle
		o_data          = 32'h0000_0000; // bus driven to zero before first beat
	end
	// one transfer: gap idle clocks, then one low clock of ready
	task automatic give(input int gap, input logic both, input logic [BCT_DATA_W-1:0] d);
		// keep the same small offset after every edge, never change on the edge itself
		repeat (gap) begin
			@(posedge i_clk_sys);
			#1;
		end
		o_burst_ready_n = 1'b0;          // low means ready
		o_ready_n       = ~both;         // abort only when asked
		o_data          = d;             // valid with ready
		@(posedge i_clk_sys);
		#1;
		o_burst_ready_n = BCT_PIN_IDLE;  // released, pull-up wins
		o_ready_n       = BCT_PIN_IDLE;  // released
		o_data          = ~d;            // stale bus must not be latched
	endtask
endmodule

// File: bct_term_tb.sv
// bct_term_tb: self-checking bench for the bus cycle termination block
// assumes bct_partner plays the far side of the ready and data pins
`timescale 1ns/1ps
module bct_term_tb;
	import bct_pkg::*;
	logic                  clk, rst, start, hold; // bench-driven inputs
	bct_req_t              req;                   // cycle kind
	wire logic             bst_ready_n, rdy_n;    // ready pins from partner
	wire logic [BCT_DATA_W-1:0] data;             // data pins from partner
	logic                  ft_n, oe, busy;        // design pin and status
	bct_beat_t             beat;                  // transfer report
	int                    err_count, n_tests;    // verdict counters

	bct_term i_bct_term (.i_clk_sys(clk), .i_rst(rst), .i_start(start), .i_req(req),
		.i_hold(hold), .i_burst_ready_n(bst_ready_n), .i_ready_n(rdy_n), .i_data(data),
		.o_final_transfer_n(ft_n), .o_final_transfer_oe(oe), .o_busy(busy), .o_beat(beat));
	bct_partner i_bct_partner (.i_clk_sys(clk), .o_burst_ready_n(bst_ready_n),
		.o_ready_n(rdy_n), .o_data(data));

	// 125 MHz bus clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// compare and count; the value seen must match exactly
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask
	// pulse start with the cycle kind for one clock
	task automatic go(input logic burst, input logic wr);
		start = 1'b1;
		req   = '{burst: burst, write: wr};
		@(posedge clk);
		#1;
		start = 1'b0;
		@(posedge clk);
		#1;
	endtask
	// wait a bounded time for one transfer report
	task automatic catch(output logic found, output bct_beat_t b);
		found = 1'b0;
		for (int k = 0; k < 12 && !found; k++) begin
			@(posedge clk);
			#1;
			if (beat.valid === 1'b1) begin
				found = 1'b1;
				b     = beat;
			end
		end
	endtask
	// four-beat read: pin low only before the fourth beat
	task automatic t_burst;
		logic f;
		bct_beat_t b;
		go(1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			chk("ft_n", {31'h0, i != 3}, {31'h0, ft_n});
			i_bct_partner.give(0, 1'b0, 32'hC0DE_0000 + i);
			catch(f, b);
			chk("found", 32'h1, {31'h0, f});
			chk("index", i, {30'h0, b.index});
			chk("data", 32'hC0DE_0000 + i, b.data);
			chk("last", {31'h0, i == 3}, {31'h0, b.last});
		end
		chk("busy", 32'h0, {31'h0, busy});
	endtask
	// single read and single write each carry the pin on their only beat
	task automatic t_single(input logic wr);
		logic f;
		bct_beat_t b;
		go(1'b0, wr);
		chk("busy run", 32'h1, {31'h0, busy});
		chk("ft_n", 32'h0, {31'h0, ft_n});
		i_bct_partner.give(1, 1'b0, 32'h5A5A_F00D);
		catch(f, b);
		chk("last", 32'h1, {31'h0, f & b.last});
		if (!wr) chk("data", 32'h5A5A_F00D, b.data);
		chk("busy", 32'h0, {31'h0, busy});
	endtask
	// both readies together end a burst early
	task automatic t_abort;
		logic f;
		bct_beat_t b;
		go(1'b1, 1'b0);
		i_bct_partner.give(1, 1'b1, 32'h1234_ABCD);
		catch(f, b);
		chk("abort", 32'h1, {31'h0, f & b.abort & b.last});
		chk("busy", 32'h0, {31'h0, busy});
	endtask
	// ready while idle gives no transfer
	task automatic t_idle;
		logic f;
		bct_beat_t b;
		i_bct_partner.give(0, 1'b0, 32'hDEAD_BEEF);
		catch(f, b);
		chk("idle beat", 32'h0, {31'h0, f});
	endtask
	// hold releases the pin and blocks starts
	task automatic t_hold;
		hold = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("oe hold", 32'h0, {31'h0, oe});
		go(1'b0, 1'b0);
		chk("busy hold", 32'h0, {31'h0, busy});
		hold = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("oe", 32'h1, {31'h0, oe});
		chk("ft_n", 32'h1, {31'h0, ft_n});
	endtask
	// verdict and end of run
	task automatic test_done;
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		err_count = 0;
		n_tests   = 0;
		rst       = 1'b1;
		start     = 1'b0;
		hold      = 1'b0;
		req       = '0;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("ft_n rst", 32'h1, {31'h0, ft_n});
		t_idle;
		t_single(1'b0);
		t_single(1'b1);
		t_burst;
		t_abort;
		t_hold;
		test_done;
	end
	// watchdog well beyond the few dozen clocks the tests need
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		test_done;
	end
endmodule
